// *** rtl/otpsc_top.v ***
// Purpose: Security configuration and OTP programming ports of a tile
// Assumes: All inputs synchronous to clk_sys_i; OTP word addresses map sectors by top bits
// Notes: Security word loaded once after reset and then frozen
// Behaviour
// - Bit 0 blocks test-port state access
// - Bit 1 refuses inter-tile state requests
// - Both bits isolate tile as secure island
// - Bit 5 boots from OTP address zero
// - Bit 7 enables spare OTP rows
// - Bits 8-11 lock sectors 0-3
// - Bit 12 locks all OTP programming
// - Bit 13 denies test-port OTP access
// - Bit 14 ignores global debug pin
// - Bits 21-15 are readable spare bits
// - Bits 31-22 extend test-port user code
// - Address port 16 bits, id 0x100200
// - Data port 32 bits, id 0x200100
// - Control port 16 bits, id 0x100300
// - Config index 0x07 reads security copy
`include "otpsc_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module otpsc_top #(
	parameter AW = 8
) (
	input wire clk_sys_i, // Tile clock
	input wire rst_i, // Sync reset, active high
	input wire port_wr_i, // Processor port write strobe
	input wire port_rd_i, // Processor port read strobe
	input wire [23:0] port_id_i, // Port resource identifier
	input wire [31:0] port_wdata_i, // Port write data
	input wire port_jtag_i, // Access comes from test port
	input wire [7:0] cfg_idx_i, // Config register index
	input wire cfg_rd_i, // Config read strobe
	input wire jtag_state_req_i, // Test port asks for state
	input wire link_state_req_i, // Other tile asks for state
	input wire debug_pin_i, // Global debug request pin
	output reg [31:0] port_rdata_o, // Port read data
	output reg port_err_o, // Programming refused pulse
	output reg [31:0] cfg_rdata_o, // Config read data
	output reg jtag_state_ok_o, // Test port state grant
	output reg link_state_ok_o, // Inter-tile state grant
	output reg secure_island_o, // Tile fully isolated
	output reg debug_req_o, // Debug request to core
	output reg boot_otp_o, // Boot from OTP
	output reg [15:0] boot_addr_o, // Boot start address
	output reg [9:0] user_id_ext_o, // User code extension
	output reg sec_valid_o // Security word loaded
);
	reg [1:0] state_q, state_d;
	reg [31:0] sec_q;
	reg [15:0] addr_q;
	reg [31:0] data_q;
	reg arr_rd, arr_wr;
	reg [AW-1:0] arr_addr;
	wire [31:0] arr_rdata;
	wire sec_jtag_dis = sec_q[`OTPSC_BIT_JTAG_DIS];
	wire sec_link_dis = sec_q[`OTPSC_BIT_LINK_DIS];
	wire [3:0] sec_locks = sec_q[`OTPSC_LOCK_LO+3:`OTPSC_LOCK_LO];
	wire [1:0] sector = addr_q[AW-1:AW-`OTPSC_SECTOR_SHIFT];
	// Full-width constant, cut to the array's address width below
	wire [15:0] sec_addr = `OTPSC_SEC_ADDR;
	wire is_addr = port_id_i == `OTPSC_RES_ADDR;
	wire is_data = port_id_i == `OTPSC_RES_DATA;
	wire is_ctrl = port_id_i == `OTPSC_RES_CTRL;
	wire jtag_otp_deny = port_jtag_i & sec_q[`OTPSC_BIT_JTAG_OTP_DIS];
	wire ctrl_prog = port_wr_i & is_ctrl & port_wdata_i[`OTPSC_CTRL_PROG];
	wire ctrl_read = port_wr_i & is_ctrl & port_wdata_i[`OTPSC_CTRL_READ];
	wire ctrl_sec = port_wdata_i[`OTPSC_CTRL_SEC];
	// Security word itself lives only behind the master lock
	wire prog_lock = sec_q[`OTPSC_BIT_MASTER_LOCK]
		| (~ctrl_sec & sec_locks[sector]);
	wire prog_ok = ctrl_prog & ~prog_lock & ~jtag_otp_deny & (state_q == `OTPSC_ST_RUN);

	otpsc_array #(
		.AW(AW),
		.DW(32)
	) u_array (
		.clk_sys_i(clk_sys_i),
		.rd_i(arr_rd),
		.wr_i(arr_wr),
		.spare_i(sec_q[`OTPSC_BIT_REDUND]),
		.addr_i(arr_addr),
		.wdata_i(data_q),
		.rdata_o(arr_rdata)
	);

	always @* begin
		state_d = state_q;
		arr_rd = 1'b0;
		arr_wr = 1'b0;
		arr_addr = addr_q[AW-1:0];
		case (state_q)
		`OTPSC_ST_LOAD: begin
			arr_rd = 1'b1;
			arr_addr = sec_addr[AW-1:0];
			state_d = `OTPSC_ST_WAIT;
		end
		`OTPSC_ST_WAIT: state_d = `OTPSC_ST_RUN;
		`OTPSC_ST_RUN: begin
			if (ctrl_sec)
				arr_addr = sec_addr[AW-1:0];
			arr_wr = prog_ok;
			arr_rd = ctrl_read & ~jtag_otp_deny;
			if (prog_ok)
				state_d = `OTPSC_ST_PROG;
		end
		`OTPSC_ST_PROG: state_d = `OTPSC_ST_RUN;
		default: state_d = `OTPSC_ST_LOAD;
		endcase
	end

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_q <= `OTPSC_ST_LOAD;
			sec_q <= 32'h0000_0000;
			addr_q <= 16'h0000;
			data_q <= 32'h0000_0000;
			port_rdata_o <= 32'h0000_0000;
			port_err_o <= 1'b0;
			cfg_rdata_o <= 32'h0000_0000;
			jtag_state_ok_o <= 1'b0;
			link_state_ok_o <= 1'b0;
			secure_island_o <= 1'b0;
			debug_req_o <= 1'b0;
			boot_otp_o <= 1'b0;
			boot_addr_o <= 16'h0000;
			user_id_ext_o <= 10'h000;
			sec_valid_o <= 1'b0;
		end else begin
			state_q <= state_d;
			// Captured once; programming the word later has no effect till reset
			if (state_q == `OTPSC_ST_WAIT) begin
				sec_q <= arr_rdata;
				sec_valid_o <= 1'b1;
			end
			if (port_wr_i && is_addr && !jtag_otp_deny)
				addr_q <= port_wdata_i[15:0];
			if (port_wr_i && is_data && !jtag_otp_deny)
				data_q <= port_wdata_i;
			port_err_o <= ctrl_prog & ~prog_ok;
			if (port_rd_i && !jtag_otp_deny)
				port_rdata_o <= is_data ? arr_rdata : (is_addr ? {16'h0000, addr_q} : 32'h0000_0000);
			else if (port_rd_i)
				port_rdata_o <= 32'h0000_0000;
			if (cfg_rd_i)
				cfg_rdata_o <= (cfg_idx_i == `OTPSC_CFG_SECURITY) ? sec_q : 32'h0000_0000;
			// Grants held low until the word is valid, so nothing leaks early
			jtag_state_ok_o <= sec_valid_o & jtag_state_req_i & ~sec_jtag_dis;
			link_state_ok_o <= sec_valid_o & link_state_req_i & ~sec_link_dis;
			secure_island_o <= sec_jtag_dis & sec_link_dis;
			debug_req_o <= sec_valid_o & debug_pin_i & ~sec_q[`OTPSC_BIT_GDBG_DIS];
			boot_otp_o <= sec_q[`OTPSC_BIT_SEC_BOOT];
			boot_addr_o <= `OTPSC_SEC_ADDR;
			user_id_ext_o <= sec_q[`OTPSC_UID_HI:`OTPSC_UID_LO];
		end
	end
endmodule // otpsc_top
`default_nettype wire

// *** rtl/otpsc_defines.vh ***
// Purpose: Constants for the OTP security configuration block
// Assumes: Included by bare name
// Notes: Bit positions within the security word and port identifiers
`ifndef OTPSC_DEFINES_VH
`define OTPSC_DEFINES_VH
`define OTPSC_BIT_JTAG_DIS 0
`define OTPSC_BIT_LINK_DIS 1
`define OTPSC_BIT_SEC_BOOT 5
`define OTPSC_BIT_REDUND 7
`define OTPSC_LOCK_LO 8
`define OTPSC_BIT_MASTER_LOCK 12
`define OTPSC_BIT_JTAG_OTP_DIS 13
`define OTPSC_BIT_GDBG_DIS 14
`define OTPSC_GP_HI 21
`define OTPSC_GP_LO 15
`define OTPSC_UID_HI 31
`define OTPSC_UID_LO 22
`define OTPSC_RES_ADDR 24'h100200
`define OTPSC_RES_DATA 24'h200100
`define OTPSC_RES_CTRL 24'h100300
`define OTPSC_CFG_SECURITY 8'h07
`define OTPSC_SEC_ADDR 16'h0000
`define OTPSC_SECTOR_SHIFT 2
`define OTPSC_CTRL_PROG 0
`define OTPSC_CTRL_READ 1
`define OTPSC_CTRL_SEC 2
`define OTPSC_ST_LOAD 2'h0
`define OTPSC_ST_WAIT 2'h1
`define OTPSC_ST_RUN 2'h2
`define OTPSC_ST_PROG 2'h3
`endif

// *** rtl/otpsc_array.v ***
// Purpose: Small OTP array model store, registered read
// Assumes: Bits only ever go from 0 to 1
// Notes: Spare rows answer for the top rows when redundancy is on
`timescale 1ns/1ns
`default_nettype none
module otpsc_array #(
	parameter AW = 8,
	parameter DW = 32
) (
	input wire clk_sys_i, // Tile clock
	input wire rd_i, // Read strobe
	input wire wr_i, // Program strobe
	input wire spare_i, // Use spare rows
	input wire [AW-1:0] addr_i, // Word address
	input wire [DW-1:0] wdata_i, // Bits to burn
	output reg [DW-1:0] rdata_o // Registered read data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	reg [DW-1:0] spare [0:3];
	wire use_spare = spare_i & (&addr_i[AW-1:2]);
	integer i;
	initial begin
		for (i = 0; i < (1<<AW); i = i + 1)
			mem[i] = {DW{1'b0}};
		for (i = 0; i < 4; i = i + 1)
			spare[i] = {DW{1'b0}};
	end
	always @(posedge clk_sys_i) begin
		// Fuses only accumulate ones
		if (wr_i && use_spare)
			spare[addr_i[1:0]] <= spare[addr_i[1:0]] | wdata_i;
		else if (wr_i)
			mem[addr_i] <= mem[addr_i] | wdata_i;
		if (rd_i)
			rdata_o <= use_spare ? spare[addr_i[1:0]] : mem[addr_i];
	end
endmodule // otpsc_array
`default_nettype wire

// *** sim/otpsc_sva.sv ***
// Purpose: Port checks for the security block
// Assumes: Bound to otpsc_top
// Notes: Copy and hold checks wait for a settled word, the island check for an island flag held two cycles; grant checks do not
`timescale 1ns/1ns
`default_nettype none
module otpsc_sva (
	input wire clk_sys_i, rst_i, cfg_rd_i, port_wr_i, port_err_o, // Controls
	input wire jtag_state_req_i, link_state_req_i, debug_pin_i, // Requests
	input wire jtag_state_ok_o, link_state_ok_o, debug_req_o, // Grants
	input wire secure_island_o, boot_otp_o, sec_valid_o, // Status
	input wire [7:0] cfg_idx_i, // Index
	input wire [31:0] cfg_rdata_o, // Config data
	input wire [15:0] boot_addr_o, // Boot address
	input wire [9:0] user_id_ext_o // User code
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_jg; !jtag_state_req_i |=> !jtag_state_ok_o; endproperty
	a_jg: assert property (p_jg) else $error("test grant leak");
	property p_lk; !link_state_req_i |=> !link_state_ok_o; endproperty
	a_lk: assert property (p_lk) else $error("link grant leak");
	property p_is; secure_island_o && $past(secure_island_o) |-> !jtag_state_ok_o && !link_state_ok_o; endproperty
	a_is: assert property (p_is) else $error("island open");
	property p_bt; boot_otp_o |-> boot_addr_o == 16'h0000; endproperty
	a_bt: assert property (p_bt) else $error("boot addr");
	property p_dg; !debug_pin_i |=> !debug_req_o; endproperty
	a_dg: assert property (p_dg) else $error("debug leak");
	property p_er; port_err_o |-> $past(port_wr_i) || $past(port_wr_i, 2); endproperty
	a_er: assert property (p_er) else $error("stray refusal");
	property p_cf; cfg_rd_i && cfg_idx_i == 8'h07 && sec_valid_o && $past(sec_valid_o) |=> cfg_rdata_o[31:22] == user_id_ext_o && cfg_rdata_o[5] == boot_otp_o; endproperty
	a_cf: assert property (p_cf) else $error("copy mismatch");
	property p_hd; sec_valid_o [*2] |=> sec_valid_o && $stable(user_id_ext_o) && $stable(boot_otp_o); endproperty
	a_hd: assert property (p_hd) else $error("word moved");
endmodule // otpsc_sva
`default_nettype wire

// *** sim/otpsc_cpu.sv ***
// Purpose: Software side of the OTP ports
// Assumes: Bench calls wr and rd
// Notes: Idle data inverted, never left stale
`timescale 1ns/1ns
`default_nettype none
module otpsc_cpu (
	input wire clk_sys_i, // Clock
	output logic port_wr_i, port_rd_i, port_jtag_i, // Strobes
	output logic [23:0] port_id_i, // Resource id
	output logic [31:0] port_wdata_i // Data
);
	initial {port_wr_i, port_rd_i, port_jtag_i, port_id_i, port_wdata_i} = '0;
	task automatic wr(input [23:0] id, input [31:0] d);
		@(posedge clk_sys_i) #1;
		{port_wr_i, port_id_i, port_wdata_i} = {1'b1, id, d};
		@(posedge clk_sys_i) #1;
		port_wr_i = 0;
		port_wdata_i = ~d;
	endtask
	task automatic jt(input b);
		@(posedge clk_sys_i) #1;
		port_jtag_i = b;
	endtask
	task automatic rd(input [23:0] id);
		@(posedge clk_sys_i) #1;
		{port_rd_i, port_id_i} = {1'b1, id};
		@(posedge clk_sys_i) #1;
		port_rd_i = 0;
	endtask
endmodule // otpsc_cpu
`default_nettype wire

// *** sim/otp_security_config_tb.sv ***
// Purpose: Self-checking bench for otpsc_top
// Assumes: OTP contents survive reset
// Notes: A new security word needs a fresh reset
`timescale 1ns/1ns
`default_nettype none
module otp_security_config_tb;
	logic clk_sys_i = 0, rst_i = 1, cfg_rd_i = 0, jtag_state_req_i = 0, link_state_req_i = 0;
	logic debug_pin_i = 0, c, p;
	logic [7:0] cfg_idx_i = 0;
	wire port_wr_i, port_rd_i, port_jtag_i, port_err_o, jtag_state_ok_o, link_state_ok_o;
	wire secure_island_o, debug_req_o, boot_otp_o, sec_valid_o;
	wire [23:0] port_id_i;
	wire [31:0] port_wdata_i, port_rdata_o, cfg_rdata_o;
	wire [15:0] boot_addr_o;
	wire [9:0] user_id_ext_o;
	int fail_count = 0, cmp_count = 0, cyc = 0, errs = 0;
	logic [31:0] exp_q[$], d, w;
	localparam [23:0] AD = 24'h100200, DA = 24'h200100, CT = 24'h100300;
	otpsc_top otpsc_top_inst (.*);
	otpsc_cpu cpu (.*);
	initial forever #25 clk_sys_i = ~clk_sys_i;
	task chk(input string n, input [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s exp %h seen %h", n, e, s);
		end
	endtask
	task test_done;
		if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		c = cfg_rd_i;
		p = port_rd_i;
		if (++cyc == 1000) begin
			fail_count++;
			test_done;
		end
		#2;
		if (c) chk("cfg", cfg_rdata_o, exp_q.pop_front());
		if (p) chk("port", port_rdata_o, exp_q.pop_front());
		if (port_err_o === 1'b1) errs++;
	end
	task boot;
		@(posedge clk_sys_i) #1;
		rst_i = 1;
		repeat (5) @(posedge clk_sys_i);
		#1 rst_i = 0;
		repeat (5) @(posedge clk_sys_i);
	endtask
	task cfg(input [7:0] i, input [31:0] e);
		@(posedge clk_sys_i) #1;
		{cfg_rd_i, cfg_idx_i} = {1'b1, i};
		exp_q.push_back(e);
		@(posedge clk_sys_i) #1;
		cfg_rd_i = 0;
	endtask
	task prog(input [31:0] a, v, k);
		cpu.wr(AD, a);
		cpu.wr(DA, v);
		cpu.wr(CT, k);
		repeat (2) @(posedge clk_sys_i) #3;
	endtask
	task rdback(input [31:0] a, e);
		cpu.wr(AD, a);
		cpu.wr(CT, 32'h2);
		exp_q.push_back(e);
		cpu.rd(DA);
	endtask
	initial begin
		d = $urandom(32'h3716);
		boot;
		chk("valid", sec_valid_o, 32'h1);
		cfg(8'h07, 32'h0);
		cfg(8'h06, 32'h0);
		{jtag_state_req_i, link_state_req_i, debug_pin_i} = 3'h7;
		repeat (2) @(posedge clk_sys_i) #1;
		chk("grant", {jtag_state_ok_o, link_state_ok_o, debug_req_o}, 32'h7);
		d = $urandom;
		prog(32'h40, d, 32'h1);
		rdback(32'h40, d);
		prog(32'hfc, d, 32'h1);
		w = $urandom;
		w[14:0] = 15'h4223;
		prog(32'h0, w, 32'h5);
		boot;
		cfg(8'h07, w);
		chk("island", {secure_island_o, boot_otp_o, boot_addr_o}, 32'h30000);
		chk("uid", user_id_ext_o, w[31:22]);
		chk("gated", {jtag_state_ok_o, link_state_ok_o, debug_req_o}, 32'h0);
		prog(32'h40, ~d, 32'h1);
		prog(32'h4, d, 32'h1);
		rdback(32'h4, d);
		rdback(32'h40, d);
		chk("lock", errs, 32'h1);
		prog(32'h0, 32'h3080, 32'h5);
		boot;
		cfg(8'h07, w | 32'h3080);
		prog(32'h8, d, 32'h1);
		chk("master", errs, 32'h2);
		rdback(32'hfc, 32'h0);
		rdback(32'h4, d);
		cpu.jt(1'b1);
		exp_q.push_back(32'h0);
		cpu.rd(DA);
		repeat (2) @(posedge clk_sys_i) #3;
		test_done;
	end
endmodule // otp_security_config_tb
bind otpsc_top otpsc_sva otpsc_sva_inst (.*);
`default_nettype wire
